/* bench/cdf_ctl_model.sv */
// serial configuration controller model
`timescale 1ns/1ns
`default_nettype none
module cdf_ctl_model (
	input  wire logic core_clk,
	output logic      shift_clk,
	output logic      serial_data_in,
	output logic      load_strobe
);
	// idle: lines rest at their pulled-down level
	initial begin
		shift_clk = 1'b0;
		serial_data_in = 1'b0;
		load_strobe = 1'b0;
	end
	// whole word, top bit first, then the load strobe
	task automatic send(input logic [21:0] w);
		for (int i = 21; i >= 0; i--) begin
			@(posedge core_clk) serial_data_in <= w[i];
			@(posedge core_clk) shift_clk <= 1'b1;
			repeat (2) @(posedge core_clk);
			shift_clk <= 1'b0;
		end
		@(posedge core_clk) serial_data_in <= 1'b0;
		load_strobe <= 1'b1;
		repeat (2) @(posedge core_clk);
		load_strobe <= 1'b0;
	endtask
endmodule // cdf_ctl_model
`default_nettype wire

/* bench/cdf_ctrl_asserts.sv */
// checker on the fanout control ports
`timescale 1ns/1ns
`default_nettype none
module cdf_ctrl_asserts #(
	parameter int CFG_W = 22
) (
	input wire logic             core_clk,
	input wire logic             sys_rst,
	input wire logic             clk_en,
	input wire logic             shift_clk,
	input wire logic             serial_data_in,
	input wire logic             load_strobe,
	input wire logic             global_oe,
	input wire logic             divider_reset_n,
	input wire logic             serial_data_out,
	input wire logic [7:0]       out_p,
	input wire logic [7:0]       out_n,
	input wire logic [7:0]       out_active,
	input wire logic [7:0]       out_type_lvpecl,
	input wire logic             configured,
	input wire logic [CFG_W-1:0] active_cfg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// pin, word and clock enable held long enough to reach the outputs
	sequence s_steady;
		(global_oe && configured && clk_en)[*3] ##0 $stable(active_cfg);
	endsequence
	a_pin_off: assert property ((!global_oe && clk_en)[*3] |-> out_active == 8'h00) else $error("on, pin low");
	a_ena_map: assert property (s_steady |-> out_active == active_cfg[9:2]) else $error("enable map");
	a_off_static: assert property (out_n == ~out_p && (~out_active & (out_p | out_type_lvpecl)) == 8'h00)
		else $error("disabled level");
	a_unconf_off: assert property (!configured |-> out_active == 8'h00) else $error("on before load");
	a_type_map: assert property (s_steady |-> out_type_lvpecl == (out_active & {{6{active_cfg[1]}},
		{2{active_cfg[0]}}})) else $error("type map");
	a_load_take: assert property ($rose(load_strobe) && clk_en |=> configured) else $error("load missed");
	a_cfg_hold: assert property (!$rose(load_strobe) |=> $stable(active_cfg)) else $error("word moved");
	a_read_back: assert property ($rose(load_strobe) && clk_en |-> ##2 serial_data_out == active_cfg[CFG_W-1])
		else $error("read back");
	a_div_hold: assert property ((!divider_reset_n)[*3] |-> out_p == 8'h00) else $error("divider ran");
	a_div_start: assert property ($rose(divider_reset_n) && clk_en |-> ##2 out_p == out_active)
		else $error("start skew");
	c_load: cover property ($rose(load_strobe));
	c_pin_off: cover property (!global_oe && configured);
	c_div_go: cover property ($rose(divider_reset_n));
endmodule // cdf_ctrl_asserts
bind cdf_fanout_ctrl cdf_ctrl_asserts #(.CFG_W(CFG_W)) i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
	.clk_en(clk_en), .shift_clk(shift_clk), .serial_data_in(serial_data_in), .load_strobe(load_strobe),
	.global_oe(global_oe), .divider_reset_n(divider_reset_n), .serial_data_out(serial_data_out),
	.out_p(out_p), .out_n(out_n), .out_active(out_active), .out_type_lvpecl(out_type_lvpecl),
	.configured(configured), .active_cfg(active_cfg));
`default_nettype wire

/* bench/clock_divider_fanout_config_test.sv */
// testbench for the fanout control block
`timescale 1ns/1ns
`default_nettype none
module clock_divider_fanout_config_test;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        global_oe = 1'b0;
	logic        divider_reset_n = 1'b1;
	logic        clk_en = 1'b1;
	logic        shift_clk, serial_data_in, load_strobe, serial_data_out, configured;
	logic [7:0]  out_p, out_n, out_active, out_type_lvpecl;
	logic [21:0] active_cfg;
	int          n_errors = 0;
	int          compares = 0;
	// 250 MHz core clock
	always #2 core_clk = ~core_clk;
	cdf_ctl_model i_ctl (.core_clk(core_clk), .shift_clk(shift_clk), .serial_data_in(serial_data_in),
		.load_strobe(load_strobe));
	cdf_fanout_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .shift_clk(shift_clk),
		.serial_data_in(serial_data_in), .load_strobe(load_strobe), .global_oe(global_oe),
		.divider_reset_n(divider_reset_n), .serial_data_out(serial_data_out), .out_p(out_p), .out_n(out_n),
		.out_active(out_active), .out_type_lvpecl(out_type_lvpecl), .configured(configured),
		.active_cfg(active_cfg));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// word from codes (bank A in the low three bits), enables and types
	function automatic logic [21:0] mk(input logic [11:0] c, input logic [7:0] oe, input logic [1:0] ty);
		logic [21:0] w;
		w = {12'h000, oe, ty};
		for (int b = 0; b < 4; b++) w[10+3*b +: 3] = {c[3*b], c[3*b+1], c[3*b+2]};
		return w;
	endfunction
	task automatic load(input logic [21:0] w);
		i_ctl.send(w);
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("active_cfg", w, active_cfg);
		chk("configured", 1'b1, configured);
		chk("read back", w[21], serial_data_out);
	endtask
	// cycles that bank output b stays at level v
	task automatic run_len(input int b, input logic v, output int k);
		k = 0;
		while (out_p[2*b] === v && k < 20) begin
			k++;
			@(negedge core_clk);
		end
	endtask
	// off before a word, then every type combination
	task automatic t_start;
		logic [7:0] e;
		@(posedge core_clk) global_oe <= 1'b1;
		repeat (4) @(negedge core_clk);
		chk("unconfigured", 8'h00, out_active);
		chk("unconfigured flag", 1'b0, configured);
		for (int t = 0; t < 4; t++) begin
			e = 8'hA5 ^ 8'(t);
			load(mk(12'h000, e, 2'(t)));
			chk("enables", e, out_active);
			chk("types", e & {{6{t[1]}}, {2{t[0]}}}, out_type_lvpecl);
			chk("off low", 8'h00, out_p & ~e);
			chk("off high", 8'(~e), out_n & ~e);
		end
	endtask
	// clock enable low freezes all state, then the pin takes over again
	task automatic t_freeze;
		logic [7:0] held;
		@(negedge core_clk) held = out_active;
		@(posedge core_clk) clk_en <= 1'b0;
		global_oe <= 1'b0;
		repeat (4) @(negedge core_clk);
		chk("frozen", held, out_active);
		@(posedge core_clk) clk_en <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk("pin off after freeze", 8'h00, out_active);
		@(posedge core_clk) global_oe <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk("back on", held, out_active);
	endtask
	// pin low overrides the enable bits
	task automatic t_pin_off;
		@(posedge core_clk) global_oe <= 1'b0;
		repeat (4) @(negedge core_clk);
		chk("pin off", 8'h00, out_active);
		chk("pin off level", 8'hFF, out_n);
		@(posedge core_clk) global_oe <= 1'b1;
	endtask
	// per-bank ratios after a common divider restart
	task automatic t_div(input logic [11:0] c);
		int n, h, l, x;
		load(mk(c, 8'hFF, 2'b00));
		@(posedge core_clk) divider_reset_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		divider_reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("start high", 8'hFF, out_p);
		for (int b = 0; b < 4; b++) begin
			n = (c[3*b +: 3] == 3'h7) ? 8 : int'(c[3*b +: 3]) + 1;
			run_len(b, 1'b1, x);
			run_len(b, 1'b0, x);
			run_len(b, 1'b1, h);
			run_len(b, 1'b0, l);
			chk("high", (n == 1) ? 1 : (n + 1) / 2, h);
			chk("low", (n == 1) ? 1 : n / 2, l);
		end
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_start;
		t_freeze;
		t_pin_off;
		t_div({3'h3, 3'h2, 3'h1, 3'h0});
		t_div({3'h7, 3'h7, 3'h5, 3'h4});
		tally_and_finish;
	end
	// cuts a hung run short
	initial begin
		#100000;
		n_errors++;
		tally_and_finish;
	end
endmodule // clock_divider_fanout_config_test
`default_nettype wire

/* core/cdf_bank_div.sv */
// one bank divider with code decode and glitch-free ratio change
`timescale 1ns/1ns
`default_nettype none
module cdf_bank_div (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       div_hold,
	input  wire logic [2:0] div_code,
	output logic            div_out
);
	// ----------------------------------------------------------------
	// ratio decode
	// ----------------------------------------------------------------
	function automatic logic [3:0] cdf_ratio(input logic [2:0] code);
		case (code)
			cdf_pkg::CODE_DIV1: cdf_ratio = 4'h1;
			cdf_pkg::CODE_DIV2: cdf_ratio = 4'h2;
			cdf_pkg::CODE_DIV3: cdf_ratio = 4'h3;
			cdf_pkg::CODE_DIV4: cdf_ratio = 4'h4;
			cdf_pkg::CODE_DIV5: cdf_ratio = 4'h5;
			cdf_pkg::CODE_DIV6: cdf_ratio = 4'h6;
			cdf_pkg::CODE_DIV8: cdf_ratio = 4'h8;
			default:            cdf_ratio = 4'h1; // reserved code runs as divide by one
		endcase
	endfunction

	logic [3:0] ratio_r;
	logic [3:0] cnt_r;
	logic [3:0] ratio_live;
	logic       hi_phase;
	logic       wrap;

	assign ratio_live = cdf_ratio(div_code);
	assign wrap       = (cnt_r == ratio_r - 4'h1);
	// high for the first ceil(n/2) counts; divide by one toggles on every enabled cycle
	assign hi_phase   = (cnt_r < ((ratio_r + 4'h1) >> 1));

	// ----------------------------------------------------------------
	// counter: held at zero in reset, ratio latched only at wrap or during hold
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r   <= 4'h0;
			ratio_r <= 4'h1;
		end else if (clk_en) begin
			if (div_hold) begin
				cnt_r   <= 4'h0;
				ratio_r <= ratio_live;
			end else if (wrap) begin
				cnt_r   <= 4'h0;
				ratio_r <= ratio_live;
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end

	// registered output; first high appears on the edge after hold release
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_out <= 1'b0;
		end else if (clk_en) begin
			if (div_hold) begin
				div_out <= 1'b0;
			end else if (ratio_r == 4'h1) begin
				div_out <= ~div_out;
			end else begin
				div_out <= hi_phase;
			end
		end
	end
endmodule // cdf_bank_div
`default_nettype wire

/* core/cdf_fanout_ctrl.sv */
// configuration port, output gating and bank dividers of the fanout buffer
// Operation
// - global enable low forces every output disabled, ignoring per-output enables
// - global enable high: each output follows its own enable bit
// - disabled output is static low/high in LVDS style
// - outputs stay disabled after power-up until a word is loaded
// - bit D1 types bank A, D2 types banks B-D; low LVDS, high LVPECL
// - each bank divides by 1,2,3,4,5,6 or 8 independently
// - divider code 000..101 give 1..6, 111 gives 8, 110 reserved
// - divider codes sit at D22..D11, bit 0 first per bank D,C,B,A
// - enables sit at D10..D3: D1,D0,C1,C0,B1,B0,A1,A0
// - divider reset low holds all dividers in reset
// - on divider reset release all dividers start and go high together
// - shifted bits become active when the load strobe goes high
// - data-out pin lets the controller read the port back
`timescale 1ns/1ns
`default_nettype none
module cdf_fanout_ctrl #(
	parameter int CFG_W = cdf_pkg::CFG_WIDTH
) (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       shift_clk,
	input  wire logic       serial_data_in,
	input  wire logic       load_strobe,
	input  wire logic       global_oe,
	input  wire logic       divider_reset_n,
	output logic            serial_data_out,
	output logic [7:0]      out_p,
	output logic [7:0]      out_n,
	output logic [7:0]      out_active,
	output logic [7:0]      out_type_lvpecl,
	output logic            configured,
	output logic [CFG_W-1:0] active_cfg
);
	// ----------------------------------------------------------------
	// serial input edge detection
	// ----------------------------------------------------------------
	logic             sclk_d_r;
	logic             le_d_r;
	logic [CFG_W-1:0] shift_r;
	logic [CFG_W-1:0] cfg_r;
	logic             loaded_r;
	logic             sclk_rise;
	logic             le_rise;
	logic [3:0]       bank_clk;
	logic [7:0]       out_en;
	logic [7:0]       oe_bits;

	assign sclk_rise = shift_clk & ~sclk_d_r;
	assign le_rise   = load_strobe & ~le_d_r;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_d_r <= 1'b0;
			le_d_r   <= 1'b0;
		end else if (clk_en) begin
			sclk_d_r <= shift_clk;
			le_d_r   <= load_strobe;
		end
	end

	// ----------------------------------------------------------------
	// shift register: first bit sent ends at the top (D22)
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_r <= cdf_pkg::CFG_RESET;
		end else if (clk_en && sclk_rise && !load_strobe) begin
			shift_r <= {shift_r[CFG_W-2:0], serial_data_in};
		end
	end

	// readback: bit leaving the top of the register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_data_out <= 1'b0;
		end else if (clk_en) begin
			serial_data_out <= shift_r[CFG_W-1];
		end
	end

	// ----------------------------------------------------------------
	// active word, latched on load strobe rise
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_r    <= cdf_pkg::CFG_RESET;
			loaded_r <= 1'b0;
		end else if (clk_en && le_rise) begin
			cfg_r    <= shift_r;
			loaded_r <= 1'b1;
		end
	end

	assign active_cfg = cfg_r;
	assign configured = loaded_r;

	// ----------------------------------------------------------------
	// bank dividers, index 0 = bank A .. 3 = bank D
	// ----------------------------------------------------------------
	for (genvar b = 0; b < cdf_pkg::NUM_BANKS; b++) begin : g_bank
		localparam int MSB = cdf_pkg::POS_DIV_A_MSB + b * cdf_pkg::DIV_FIELD_STRIDE;
		logic [2:0] code;
		// field is sent bit 0 first, so bit 0 sits at the highest position
		// code bit 2 sits at the field's lowest position, bit 0 two above it
		assign code = {cfg_r[MSB], cfg_r[MSB+1], cfg_r[MSB+2]};
		cdf_bank_div u_div (
			.core_clk (core_clk),
			.sys_rst  (sys_rst),
			.clk_en   (clk_en),
			.div_hold (~divider_reset_n),
			.div_code (code),
			.div_out  (bank_clk[b])
		);
	end

	// ----------------------------------------------------------------
	// enable gating and output type
	// ----------------------------------------------------------------
	assign oe_bits = cfg_r[cdf_pkg::POS_OE_LSB +: 8];
	assign out_en  = (global_oe && loaded_r) ? oe_bits : 8'h00;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_p           <= 8'h00;
			out_n           <= 8'hFF;
			out_active      <= 8'h00;
			out_type_lvpecl <= 8'h00;
		end else if (clk_en) begin
			for (int i = 0; i < cdf_pkg::NUM_OUTS; i++) begin
				out_active[i] <= out_en[i];
				if (out_en[i]) begin
					out_p[i] <= bank_clk[i/2];
					out_n[i] <= ~bank_clk[i/2];
					out_type_lvpecl[i] <= (i < 2) ? cfg_r[cdf_pkg::POS_BANK_A_TYPE]
						: cfg_r[cdf_pkg::POS_BCD_TYPE];
				end else begin
					out_p[i] <= cdf_pkg::DIS_TRUE_LVL;
					out_n[i] <= ~cdf_pkg::DIS_TRUE_LVL;
					out_type_lvpecl[i] <= cdf_pkg::TYPE_LVDS;
				end
			end
		end
	end
endmodule // cdf_fanout_ctrl
`default_nettype wire

/* core/cdf_pkg.sv */
// constants for the clock divider fanout configuration block
package cdf_pkg;
	// configuration word layout (bit index = documented position minus one)
	localparam int CFG_WIDTH        = 22;
	localparam int NUM_BANKS        = 4;
	localparam int NUM_OUTS         = 8;
	localparam int DIV_CODE_W       = 3;
	localparam int DIV_CNT_W        = 3;
	localparam int POS_BANK_A_TYPE  = 0;
	localparam int POS_BCD_TYPE     = 1;
	localparam int POS_OE_LSB       = 2;
	localparam int POS_DIV_A_MSB    = 10;
	localparam int DIV_FIELD_STRIDE = 3;
	localparam logic [21:0] CFG_RESET = 22'h000000;
	// output type encoding
	localparam logic TYPE_LVDS   = 1'b0;
	localparam logic TYPE_LVPECL = 1'b1;
	// disabled output static level: true side low, complement side high
	localparam logic DIS_TRUE_LVL = 1'b0;
	// divider codes
	localparam logic [2:0] CODE_DIV1 = 3'h0;
	localparam logic [2:0] CODE_DIV2 = 3'h1;
	localparam logic [2:0] CODE_DIV3 = 3'h2;
	localparam logic [2:0] CODE_DIV4 = 3'h3;
	localparam logic [2:0] CODE_DIV5 = 3'h4;
	localparam logic [2:0] CODE_DIV6 = 3'h5;
	localparam logic [2:0] CODE_RSVD = 3'h6;
	localparam logic [2:0] CODE_DIV8 = 3'h7;
	// serial port timing at 250 MHz (figures in ns)
	localparam int CLK_PERIOD_NS    = 4;
	localparam int SCLK_HI_MIN_NS   = 25;
	localparam int SCLK_HI_MIN_CYC  = (SCLK_HI_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MISO_DELAY_MAX_NS  = 10;
	localparam int MISO_DELAY_MAX_CYC = MISO_DELAY_MAX_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		CDF_ST_HOLD,
		CDF_ST_RUN
	} cdf_div_state_type;
endpackage
